// >>> common/fgp_defines.svh
// Register map, field positions and reset values of the port
`ifndef FGP_DEFINES_SVH
`define FGP_DEFINES_SVH

// Register indices; the byte address is four times the index
`define FGP_IDX_DATA   8'h09
`define FGP_IDX_DIR    8'h0d
`define FGP_ADDR_DATA  8'(`FGP_IDX_DATA * 4)
`define FGP_ADDR_DIR   8'(`FGP_IDX_DIR * 4)

// Field layout
`define FGP_PINS       4
`define FGP_DIR_LSB    0
`define FGP_DIR_MSB    3
`define FGP_RSV_LSB    4
`define FGP_RSV_MSB    7

// Reset values
`define FGP_DIR_RST    4'h0
`define FGP_OEN_RST    4'hf
`define FGP_RD_RST     32'h0000_0000

// Timer selections
`define FGP_PS_EXT     3'h7
`define FGP_ELS_GPIO   2'h0

// Avalon response codes
`define FGP_RESP_OKAY  2'h0
`define FGP_RESP_ERR   2'h2

`endif

// >>> common/fgp_pkg.sv
// Types shared by the port and its surroundings
package fgp_pkg;

  // Controls coming from the two timers
  typedef struct packed {
    logic [2:0]      oneSel;   // timer_one prescaler_select
    logic [2:0]      twoSel;   // timer_two prescaler_select
    logic [1:0][1:0] chEls;    // per channel {high, low} edge/level
    logic [1:0]      chOut;    // compare output value per channel
    logic [1:0]      chOutEn;  // timer wants to drive the channel
  } fgp_timer_ctl_t;

  // Signals handed to the timers
  typedef struct packed {
    logic       oneExtClk;     // timer_one_ext_clock
    logic       twoExtClk;     // timer_two_ext_clock
    logic [1:0] chIn;          // timer_two_channel_pin levels
  } fgp_timer_in_t;

  // Pad drive, enable active low
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oeN;
  } fgp_pad_t;

endpackage : fgp_pkg

// >>> verilog/fgp_pin_sync.sv
// Two-stage synchroniser for the four pin levels
module fgp_pin_sync (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] pinIn,
  output logic      [3:0] pinSync
);
  import fgp_pkg::*;

  logic [3:0] meta_r;

  // First stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : gSync
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_r[i]  <= 1'b0;
          pinSync[i] <= 1'b0;
        end else begin
          meta_r[i]  <= pinIn[i];
          pinSync[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule : fgp_pin_sync

// >>> verilog/fgp_port.sv
// Four-pin GPIO port shared with two timers, Avalon-MM slave
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`include "fgp_defines.svh"

module fgp_port (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [7:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic      [31:0]            readdata,
  output logic      [1:0]             response,
  output logic                        waitrequest,
  input  wire fgp_pkg::fgp_timer_ctl_t timerCtl,
  output fgp_pkg::fgp_timer_in_t      timerIn,
  input  wire logic [3:0]             pinIn,
  output fgp_pkg::fgp_pad_t           pad
);
  import fgp_pkg::*;

  // Prescaler code that selects the external clock pin
  function automatic logic isExtClk(input logic [2:0] sel);
    isExtClk = (sel == `FGP_PS_EXT);
  endfunction : isExtClk

  logic [3:0]  latch_r;
  logic [3:0]  dir_r;
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] readdata_nxt;
  logic [1:0]  response_nxt;
  logic [3:0]  pinSync;
  fgp_pad_t    pad_nxt;
  fgp_timer_in_t timerIn_nxt;

  // Bus decode
  wire        reqAct   = read | write;
  wire        hitData  = (address == `FGP_ADDR_DATA);
  wire        hitDir   = (address == `FGP_ADDR_DIR);
  wire        hitAny   = hitData | hitDir;
  wire        laneLow  = byteenable[0];
  wire        wrTake   = write & ack_r & laneLow;
  wire        wrData   = wrTake & hitData;
  wire        wrDir    = wrTake & hitDir;

  // One wait state: request seen, answer on the following cycle
  assign waitrequest = reqAct & ~ack_r;
  assign ack_nxt     = reqAct & ~ack_r;

  fgp_pin_sync uSync (
    .clk     (clk),
    .rst     (rst),
    .pinIn   (pinIn),
    .pinSync (pinSync)
  );

  // Pin ownership by the timers
  logic [3:0] owned;
  assign owned[3] = isExtClk(timerCtl.oneSel);
  assign owned[2] = isExtClk(timerCtl.twoSel);
  assign owned[1] = (timerCtl.chEls[1] != `FGP_ELS_GPIO);
  assign owned[0] = (timerCtl.chEls[0] != `FGP_ELS_GPIO);

  // Clock pins are never driven by the timer; channels follow it
  wire [3:0] timerDrv = {2'b00, timerCtl.chOutEn};
  wire [3:0] timerVal = {2'b00, timerCtl.chOut};

  // Direction bit only steers pins the timers leave alone
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : gPad
      assign pad_nxt.oeN[i] = owned[i] ? ~timerDrv[i]
                                       : ~dir_r[i];
      assign pad_nxt.out[i] = owned[i] ? timerVal[i]
                                       : latch_r[i];
    end
  endgenerate

  // Read mux uses the direction bit even on owned pins
  wire [3:0] dataView = (dir_r & latch_r)
                      | (~dir_r & pinSync);
  wire [7:0] dirView  = {4'h0, dir_r};

  assign readdata_nxt = hitData ? {28'h000_0000, dataView}
                      : hitDir  ? {24'h00_0000, dirView}
                      : `FGP_RD_RST;
  assign response_nxt = hitAny ? `FGP_RESP_OKAY : `FGP_RESP_ERR;

  assign timerIn_nxt.oneExtClk = owned[3] & pinSync[3];
  assign timerIn_nxt.twoExtClk = owned[2] & pinSync[2];
  assign timerIn_nxt.chIn      = pinSync[1:0];

  // Handshake and read data
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r    <= 1'b0;
      readdata <= `FGP_RD_RST;
      response <= `FGP_RESP_OKAY;
    end else begin
      ack_r <= ack_nxt;
      if (read & ~ack_r) begin
        readdata <= readdata_nxt;
        response <= response_nxt;
      end else if (write & ~ack_r) begin
        response <= response_nxt;
      end
    end
  end

  // Latches carry no reset so a reset keeps port data
  always_ff @(posedge clk) begin
    if (wrData) begin
      latch_r <= writedata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dir_r <= `FGP_DIR_RST;
    end else if (wrDir) begin
      dir_r <= writedata[`FGP_DIR_MSB:`FGP_DIR_LSB];
    end
  end

  // Pads and timer inputs leave from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      pad.out <= 4'h0;
      pad.oeN <= `FGP_OEN_RST;
      timerIn <= '0;
    end else begin
      pad     <= pad_nxt;
      timerIn <= timerIn_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence dataWrS;
    write & ack_r & laneLow & hitData;
  endsequence

  sequence dataRdReqS;
    read & ~ack_r & hitData;
  endsequence

  sequence answerS;
    ~waitrequest ##0 ack_r;
  endsequence

  sequence reqStartS;
    (read | write) & ~ack_r;
  endsequence

  sequence dirWrS;
    write & ack_r & laneLow & hitDir;
  endsequence

  property latchFollowsWrite;
    logic [3:0] wd;
    (dataWrS, wd = writedata[3:0]) |=> (latch_r == wd);
  endproperty

  property dataReadback;
    logic [3:0] exp;
    (dataRdReqS, exp = dataView) |=> answerS ##0 (readdata[3:0] == exp);
  endproperty

  latch_write_a: assert property (latchFollowsWrite)
    else $error("data latch missed a write");

  latch_keep_a: assert property (
    @(posedge clk) disable iff (1'b0)
    rst |=> (latch_r === $past(latch_r)))
    else $error("reset disturbed the data latch");

  one_clk_a: assert property (
    isExtClk(timerCtl.oneSel) |=> timerIn.oneExtClk == $past(pinSync[3]))
    else $error("pin 3 not fed to timer one");

  one_clk_off_a: assert property (
    !isExtClk(timerCtl.oneSel) |=> !timerIn.oneExtClk)
    else $error("timer one clock leaked while not selected");

  two_clk_a: assert property (
    isExtClk(timerCtl.twoSel) |=> timerIn.twoExtClk == $past(pinSync[2]))
    else $error("pin 2 not fed to timer two");

  chan_drive_a: assert property (
    (timerCtl.chEls[0] != `FGP_ELS_GPIO)
      |=> pad.oeN[0] == !$past(timerCtl.chOutEn[0])
          && pad.out[0] == $past(timerCtl.chOut[0]))
    else $error("channel 0 pin not under timer control");

  owned_dir_a: assert property (
    isExtClk(timerCtl.oneSel) && dir_r[3] |=> pad.oeN[3])
    else $error("owned clock pin driven by direction bit");

  dir_drive_a: assert property (
    !owned[1] |=> pad.oeN[1] == !$past(dir_r[1]))
    else $error("pin 1 drive does not follow direction");

  // Value only checked while driving: the latch powers up unknown
  dir_value_a: assert property (
    !owned[1] && dir_r[1] |=> pad.out[1] == $past(latch_r[1]))
    else $error("pin 1 drives a value other than its latch");

  dir_reset_a: assert property (
    @(posedge clk) disable iff (1'b0)
    rst |=> (dir_r == `FGP_DIR_RST) && (pad.oeN == `FGP_OEN_RST))
    else $error("reset left a direction bit set");

  reserved_zero_a: assert property (
    read & ~ack_r & hitDir |=> readdata[31:4] == 28'h000_0000)
    else $error("reserved direction bits read nonzero");

  read_mux_a: assert property (dataReadback)
    else $error("data read mixed latch and pin wrongly");

  input_kept_a: assert property (
    dataWrS ##0 (~dir_r[0] & ~owned[0]) |=> pad.oeN[0])
    else $error("write to input pin turned on its driver");

  // Synchroniser refills for two edges after any reset
  sync_depth_a: assert property (
    !$past(rst) && !$past(rst, 2) |-> pinSync == $past(pinIn, 2))
    else $error("pin level not two stages behind the pad");

  wait_first_a: assert property (
    reqStartS |-> waitrequest)
    else $error("first request cycle not stalled");

  wait_one_a: assert property (
    reqStartS ##1 (read | write) |-> !waitrequest)
    else $error("request stalled for more than one cycle");

  ack_single_a: assert property (
    ack_r |=> !ack_r)
    else $error("acknowledge held for two cycles");

  // Back to back requests must stall again in their first cycle
  wait_rearm_a: assert property (
    ack_r ##1 (read | write) |-> waitrequest)
    else $error("new request answered without a wait state");

  idle_nowait_a: assert property (
    !(read | write) |-> !waitrequest)
    else $error("wait asserted with no request");

  dir_write_a: assert property (
    dirWrS |=> dir_r == $past(writedata[3:0]))
    else $error("direction bits missed a write");

  dir_hold_a: assert property (
    !dirWrS |=> $stable(dir_r))
    else $error("direction bits moved without a write");

  lane_off_a: assert property (
    write & ack_r & !laneLow |=> $stable(dir_r))
    else $error("write with low lane off changed direction");

  unmapped_wr_a: assert property (
    write & ack_r & !hitAny |=> $stable(dir_r))
    else $error("unmapped write changed direction");

  unmapped_rd_a: assert property (
    read & ~ack_r & !hitAny
      |=> readdata == `FGP_RD_RST && response == `FGP_RESP_ERR)
    else $error("unmapped read not refused");

  unmapped_resp_a: assert property (
    write & ~ack_r & !hitAny |=> response == `FGP_RESP_ERR)
    else $error("unmapped write not refused");

  resp_ok_a: assert property (
    reqStartS ##0 hitAny |=> response == `FGP_RESP_OKAY)
    else $error("mapped access answered with error");

  dir_read_a: assert property (
    read & ~ack_r & hitDir |=> readdata[3:0] == $past(dir_r))
    else $error("direction read returned wrong bits");

  // Read data must stand until the master has taken it
  rd_hold_a: assert property (
    !(read & ~ack_r) |=> $stable(readdata))
    else $error("read data moved without a read");

  resp_hold_a: assert property (
    !((read | write) & ~ack_r) |=> $stable(response))
    else $error("response moved without a request");

  owned_read_a: assert property (
    dataRdReqS ##0 owned[3] ##0 !dir_r[3]
      |=> readdata[3] == $past(pinSync[3]))
    else $error("owned pin read ignored its direction bit");

  two_clk_off_a: assert property (
    !isExtClk(timerCtl.twoSel) |=> !timerIn.twoExtClk)
    else $error("timer two clock leaked while not selected");

  two_owned_a: assert property (
    isExtClk(timerCtl.twoSel) |=> pad.oeN[2])
    else $error("owned timer two clock pin is driven");

  chan_one_a: assert property (
    (timerCtl.chEls[1] != `FGP_ELS_GPIO)
      |=> pad.oeN[1] == !$past(timerCtl.chOutEn[1])
          && pad.out[1] == $past(timerCtl.chOut[1]))
    else $error("channel 1 pin not under timer control");

  chan_in_a: assert property (
    1'b1 |=> timerIn.chIn == $past(pinSync[1:0]))
    else $error("channel levels not passed to timer two");

  // Every pin the timers leave alone follows its own direction bit
  generate
    for (i = 0; i < 4; i++) begin : gDrvChk
      pin_dir_a: assert property (
        !owned[i] |=> pad.oeN[i] == !$past(dir_r[i]))
        else $error("pin drive does not follow direction");
    end
  endgenerate

  reset_out_a: assert property (
    @(posedge clk) disable iff (1'b0)
    rst |=> pad.out == 4'h0 && timerIn == '0 && readdata == `FGP_RD_RST)
    else $error("reset left an output active");

endmodule : fgp_port

// >>> tb/fgp_board.sv
// Board model: resolves each pin from the port driver and board level
module fgp_board
  import fgp_pkg::*;
(
  input  wire fgp_pkg::fgp_pad_t pad,
  input  wire logic [3:0]        extLvl,
  output logic      [3:0]        pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins show the board level, never the last driven value
  assign pinIn = (~pad.oeN & pad.out) | (pad.oeN & extLvl);
endmodule : fgp_board

// >>> tb/tb_top.sv
// Self-checking bench for the shared four-pin port
`include "fgp_defines.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fgp_pkg::*;
  logic           clk = 0;
  logic           rst = 1;
  logic [7:0]     address = 0;
  logic           read = 0;
  logic           write = 0;
  logic [31:0]    writedata = 0;
  logic [3:0]     byteenable = 4'h1;
  logic [31:0]    readdata;
  logic [1:0]     response;
  logic           waitrequest;
  fgp_timer_ctl_t tc = '0;
  fgp_timer_in_t  ti;
  logic [3:0]     pinIn;
  logic [3:0]     extLvl = 4'h5;
  fgp_pad_t       pad;
  logic [31:0]    rd;
  logic [1:0]     rsp;
  int             n_fail = 0;
  int             check_count = 0;
  int             cyc = 0;
  always #2 clk = ~clk;
  fgp_port u_dut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .response(response), .waitrequest(waitrequest),
    .timerCtl(tc), .timerIn(ti), .pinIn(pinIn), .pad(pad));
  fgp_board u_board (.pad(pad), .extLvl(extLvl), .pinIn(pinIn));
  task close_out;
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // One bus cycle; waitrequest and read data taken at the rising edge
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    rsp = response;
    read <= 0;
    write <= 0;
  endtask : acc
  // Long enough for pad flop, two sync stages and the timer flop
  task settle;
    repeat (6) @(negedge clk);
  endtask : settle
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    settle;
    acc(0, `FGP_ADDR_DIR, 0);
    `CHK(rd, 32'h0000_0000)
    `CHK(rsp, 2'h0)
    acc(1, `FGP_ADDR_DATA, 32'h0000_000a);
    acc(0, `FGP_ADDR_DATA, 0);
    `CHK(rd, 32'h0000_0005)
    // Latch loaded before the driver turns on
    acc(1, `FGP_ADDR_DIR, 32'h0000_00ff);
    acc(0, `FGP_ADDR_DIR, 0);
    `CHK(rd, 32'h0000_000f)
    settle;
    `CHK(pad.oeN, 4'h0)
    `CHK(pad.out, 4'ha)
    acc(0, `FGP_ADDR_DATA, 0);
    `CHK(rd, 32'h0000_000a)
    byteenable <= 4'h0;
    acc(1, `FGP_ADDR_DIR, 0);
    byteenable <= 4'h1;
    acc(0, `FGP_ADDR_DIR, 0);
    `CHK(rd, 32'h0000_000f)
    tc.oneSel <= 3'h7;
    tc.twoSel <= 3'h7;
    tc.chEls <= {2'h2, 2'h1};
    tc.chOut <= 2'h1;
    tc.chOutEn <= 2'h1;
    extLvl <= 4'hc;
    settle;
    `CHK(pad.oeN, 4'he)
    `CHK(pad.out[1:0], 2'h1)
    `CHK(ti.oneExtClk, 1'b1)
    `CHK(ti.twoExtClk, 1'b1)
    `CHK(ti.chIn, 2'h1)
    acc(0, `FGP_ADDR_DATA, 0);
    `CHK(rd, 32'h0000_000a)
    acc(1, `FGP_ADDR_DIR, 0);
    settle;
    acc(0, `FGP_ADDR_DATA, 0);
    `CHK(rd, 32'h0000_000d)
    tc <= '0;
    acc(1, `FGP_ADDR_DIR, 32'h0000_000f);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    settle;
    `CHK(pad.oeN, 4'hf)
    acc(1, `FGP_ADDR_DIR, 32'h0000_000f);
    acc(1, 8'h00, 32'h0000_0005);
    `CHK(rsp, 2'h2)
    acc(0, `FGP_ADDR_DATA, 0);
    `CHK(rd, 32'h0000_000a)
    acc(0, 8'h00, 0);
    `CHK(rsp, 2'h2)
    `CHK(rd, 32'h0000_0000)
    close_out;
  end
endmodule : tb_top
